// ### design/watchdog_unit.sv
`timescale 1ns/1ns
module watchdog_unit
    import wdog_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Count clock sources
    input  wire logic        lowSpeedInternalOsc,
    input  wire logic        lowSpeedExternalOsc,
    // Processor state
    input  wire logic        debugHalt,
    // System reset request
    output logic             sysResetReq
);
    wdog_cfg_t        cfg;
    logic             locked;
    logic [CNT_W-1:0] count;
    logic             reloadPend;
    logic             resetFlag;
    cause_t           cause;
    logic             tick;

    // Bus decode
    wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wrAll    = req & wb_we_i & (wb_sel_i == 4'hF);
    wire wrCtrl   = wrAll & (wb_adr_i == OFS_CTRL);
    wire wrMode   = wrAll & (wb_adr_i == OFS_MODE) & ~locked; // R5
    wire wrProt   = wrAll & (wb_adr_i == OFS_PROT);
    wire reloadOk = wrCtrl & wb_dat_i[CTRL_RELOAD_BIT] & (wb_dat_i[31:16] == RELOAD_KEY);
    wire early    = reloadOk & cfg.enable & (count > cfg.delta); // R3
    wire run      = cfg.enable & ~(cfg.dbgStop & debugHalt); // R4
    wire uflow    = tick & (count == CNT_ZERO) & ~reloadPend; // R2

    // Read mux
    wire [31:0] rdMode = {8'h00, cfg.delta, cfg.reloadVal} << MODE_VAL_LSB
                         | {24'h0, 1'b0, cfg.preSel, 1'b0, cfg.srcExt, cfg.dbgStop, cfg.enable};
    wire [31:0] rdStat = {15'h0, locked, 1'b0, cause, resetFlag, count};
    wire [31:0] rdMux  = (wb_adr_i == OFS_MODE)   ? rdMode :
                         (wb_adr_i == OFS_PROT)   ? {31'h0, locked} :
                         (wb_adr_i == OFS_STATUS) ? rdStat : 32'h0;

    wdog_tick_gen u_tick (
        .clk                 (clk),
        .reset_n             (reset_n),
        .lowSpeedInternalOsc (lowSpeedInternalOsc),
        .lowSpeedExternalOsc (lowSpeedExternalOsc),
        .srcExt              (cfg.srcExt),
        .preSel              (cfg.preSel),
        .run                 (run),
        .tick                (tick)
    );

    assign sysResetReq = resetFlag;

    // Bus acknowledge, one cycle per access
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) wb_ack_o <= 1'b0;
        else          wb_ack_o <= req;
    end

    // Read data register, loaded when a request is taken and shown with ack
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_dat_o <= 32'h0;
        end else if (req) begin
            wb_dat_o <= rdMux;
        end
    end

    // Configuration and protection
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg    <= '{1'b0, 1'b0, 1'b0, RST_PRE, RST_RELOAD, RST_DELTA};
            locked <= 1'b0;
        end else begin
            if (wrProt) locked <= (wb_dat_i[15:0] != PROT_UNLOCK); // R5
            if (wrMode) begin
                cfg.enable    <= wb_dat_i[MODE_EN_BIT];
                cfg.dbgStop   <= wb_dat_i[MODE_DBG_BIT];
                cfg.srcExt    <= wb_dat_i[MODE_SRC_BIT];
                cfg.preSel    <= wb_dat_i[MODE_PRE_LSB +: PRE_W];
                cfg.reloadVal <= wb_dat_i[MODE_VAL_LSB +: CNT_W];
                cfg.delta     <= wb_dat_i[MODE_DELTA_LSB +: CNT_W];
            end
        end
    end

    // Down-counter and reload
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count      <= RST_RELOAD;
            reloadPend <= 1'b0;
        end else if (!cfg.enable) begin
            count      <= cfg.reloadVal;
            reloadPend <= 1'b0;
        end else begin
            if (reloadOk && !early) reloadPend <= 1'b1;
            else if (tick)          reloadPend <= 1'b0;
            if (tick) begin
                if (reloadPend) count <= cfg.reloadVal; // R7
                else if (count != CNT_ZERO) count <= count - 12'h001; // R1
            end
        end
    end

    // Reset request latches until system reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            resetFlag <= 1'b0;
            cause     <= CAUSE_NONE;
        end else if (!resetFlag && (uflow || early)) begin
            resetFlag <= 1'b1; // R2 R3
            cause     <= uflow ? CAUSE_UFLOW : CAUSE_EARLY;
        end
    end

    property p_early;
        @(posedge clk) disable iff (!reset_n) early |=> sysResetReq;
    endproperty
    a_early: assert property (p_early) else $error("early reload no reset"); // R3

    property p_uflow;
        @(posedge clk) disable iff (!reset_n) uflow |=> sysResetReq && cause != CAUSE_NONE;
    endproperty
    a_uflow: assert property (p_uflow) else $error("underflow no reset"); // R2

    property p_sticky;
        @(posedge clk) disable iff (!reset_n) sysResetReq |=> sysResetReq;
    endproperty
    a_sticky: assert property (p_sticky) else $error("reset dropped"); // R2

    property p_freeze;
        @(posedge clk) disable iff (!reset_n)
            (cfg.enable && cfg.dbgStop && debugHalt) |=> $stable(count);
    endproperty
    a_freeze: assert property (p_freeze) else $error("counted in debug"); // R4

    property p_lock;
        @(posedge clk) disable iff (!reset_n) (locked && !wrProt) |=> $stable(cfg);
    endproperty
    a_lock: assert property (p_lock) else $error("locked cfg changed"); // R5

    property p_reload;
        @(posedge clk) disable iff (!reset_n)
            (tick && reloadPend && cfg.enable && !wrMode) |=> count == $past(cfg.reloadVal);
    endproperty
    a_reload: assert property (p_reload) else $error("reload not applied"); // R7

    property p_dec;
        @(posedge clk) disable iff (!reset_n)
            (tick && !reloadPend && count != CNT_ZERO && cfg.enable) |=> count == $past(count) - 12'h001;
    endproperty
    a_dec: assert property (p_dec) else $error("count not decremented"); // R1

    property p_hold;
        @(posedge clk) disable iff (!reset_n) (!tick && cfg.enable && !wrMode) |=> $stable(count);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved without tick"); // R1

    // No reset request without a cause
    property p_quiet;
        @(posedge clk) disable iff (!reset_n) (!resetFlag && !uflow && !early) |=> !sysResetReq;
    endproperty
    a_quiet: assert property (p_quiet) else $error("reset without cause"); // R2

    // First underflow records its cause
    property p_cause_uflow;
        @(posedge clk) disable iff (!reset_n) (uflow && !resetFlag) |=> cause == CAUSE_UFLOW;
    endproperty
    a_cause_uflow: assert property (p_cause_uflow) else $error("underflow cause wrong"); // R2

    // First early reload records its cause
    property p_cause_early;
        @(posedge clk) disable iff (!reset_n) (early && !uflow && !resetFlag) |=> cause == CAUSE_EARLY;
    endproperty
    a_cause_early: assert property (p_cause_early) else $error("early cause wrong"); // R3

    // In-window reload is accepted
    property p_window;
        @(posedge clk) disable iff (!reset_n) (reloadOk && cfg.enable && count <= cfg.delta) |=> reloadPend;
    endproperty
    a_window: assert property (p_window) else $error("window reload lost"); // R3

    // Counter rests at zero instead of wrapping
    property p_floor;
        @(posedge clk) disable iff (!reset_n)
            (tick && count == CNT_ZERO && !reloadPend && cfg.enable) |=> count == CNT_ZERO;
    endproperty
    a_floor: assert property (p_floor) else $error("counter wrapped"); // R2

    // Any key but the unlock key locks
    property p_lock_set;
        @(posedge clk) disable iff (!reset_n) (wrProt && wb_dat_i[15:0] != PROT_UNLOCK) |=> locked;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock not set"); // R5

    // Unlock key clears the lock
    property p_unlock;
        @(posedge clk) disable iff (!reset_n) (wrProt && wb_dat_i[15:0] == PROT_UNLOCK) |=> !locked;
    endproperty
    a_unlock: assert property (p_unlock) else $error("lock not cleared"); // R5

    // Pending reload is consumed by the tick that applies it
    property p_pend_clear;
        @(posedge clk) disable iff (!reset_n)
            (tick && reloadPend && !reloadOk && cfg.enable) |=> !reloadPend;
    endproperty
    a_pend_clear: assert property (p_pend_clear) else $error("reload pending twice"); // R7

    // Disabled counter holds the programmed reload value
    property p_disabled;
        @(posedge clk) disable iff (!reset_n)
            !cfg.enable |=> count == $past(cfg.reloadVal) && !reloadPend;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled count wrong"); // R7
endmodule

// ### design/wdog_pkg.sv
// Function
// [R1] 12-bit down-counter driven by 3-bit prescaler
// [R2] Underflow without reload asserts system reset
// [R3] Reload above delta value asserts system reset
// [R4] Optional counter freeze during debug halt
// [R5] Write protection blocks configuration changes
// [R6] Count clock from internal or external osc
// [R7] Accepted reload restores counter next tick
package wdog_pkg;
    localparam int CNT_W = 12;
    localparam int PRE_W = 3;

    // Register byte offsets
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_MODE   = 4'h4;
    localparam logic [3:0] OFS_PROT   = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;

    // Control register fields
    localparam int CTRL_RELOAD_BIT = 0;
    localparam logic [15:0] RELOAD_KEY = 16'h5FA0;

    // Mode register fields
    localparam int MODE_EN_BIT    = 0;
    localparam int MODE_DBG_BIT   = 1;
    localparam int MODE_SRC_BIT   = 2;
    localparam int MODE_PRE_LSB   = 4;
    localparam int MODE_VAL_LSB   = 8;
    localparam int MODE_DELTA_LSB = 20;

    // Protection key values
    localparam logic [15:0] PROT_UNLOCK = 16'h35CA;

    // Reset values and counter constants
    localparam logic [CNT_W-1:0] RST_RELOAD = 12'hFFF;
    localparam logic [CNT_W-1:0] RST_DELTA  = 12'hFFF;
    localparam logic [PRE_W-1:0] RST_PRE    = 3'h0;
    localparam logic [7:0]       PRE_ONE    = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO   = 12'h000;

    // Reset cause codes
    typedef enum logic [1:0] {
        CAUSE_NONE  = 2'h0,
        CAUSE_UFLOW = 2'h1,
        CAUSE_EARLY = 2'h2
    } cause_t;

    // Configuration bundle
    typedef struct packed {
        logic             enable;
        logic             dbgStop;
        logic             srcExt;
        logic [PRE_W-1:0] preSel;
        logic [CNT_W-1:0] reloadVal;
        logic [CNT_W-1:0] delta;
    } wdog_cfg_t;
endpackage

// ### design/wdog_tick_gen.sv
`timescale 1ns/1ns
module wdog_tick_gen
    import wdog_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Oscillator levels and source select
    input  wire logic             lowSpeedInternalOsc,
    input  wire logic             lowSpeedExternalOsc,
    input  wire logic             srcExt,
    // Prescaler control
    input  wire logic [PRE_W-1:0] preSel,
    input  wire logic             run,
    // Count pulse out
    output logic                  tick
);
    logic       oscDly;
    logic [7:0] preCnt;
    logic [7:0] preTop;
    wire        oscSel  = srcExt ? lowSpeedExternalOsc : lowSpeedInternalOsc; // R6
    wire        oscRise = oscSel & ~oscDly;
    wire        preWrap = (preCnt == preTop);

    // Divide ratio is two to the power of preSel
    assign preTop = 8'((PRE_ONE << preSel) - PRE_ONE); // R1
    assign tick   = run & oscRise & preWrap;

    // Edge history and prescale count
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oscDly <= 1'b0;
            preCnt <= 8'h00;
        end else begin
            oscDly <= oscSel;
            if (run && oscRise) begin
                preCnt <= preWrap ? 8'h00 : 8'(preCnt + 8'h01);
            end
        end
    end
endmodule

// ### bench/test_windowed_watchdog_timer.sv
`timescale 1ns/1ns
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin nFail++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module test_windowed_watchdog_timer;
    import wdog_pkg::*;
    typedef struct packed {
        logic        we;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
        logic [31:0] want;
    } row_t;
    localparam logic [31:0] M   = 32'h0050_0A00;
    localparam logic [31:0] UNL = {16'h0000, PROT_UNLOCK};
    // Register rows: write, partial write, reads, lock and unlock
    localparam row_t ROWS[12] = '{
        '{1'b1, OFS_MODE, 4'hF, M, 32'h0}, '{1'b0, OFS_MODE, 4'hF, 32'h0, M},
        '{1'b1, OFS_MODE, 4'h3, 32'h0, 32'h0}, '{1'b0, OFS_MODE, 4'hF, 32'h0, M},
        '{1'b0, OFS_CTRL, 4'hF, 32'h0, 32'h0}, '{1'b0, 4'h2, 4'hF, 32'h0, 32'h0},
        '{1'b1, OFS_PROT, 4'hF, 32'h0, 32'h0}, '{1'b0, OFS_PROT, 4'hF, 32'h0, 32'h1},
        '{1'b1, OFS_MODE, 4'hF, 32'h0, 32'h0}, '{1'b0, OFS_MODE, 4'hF, 32'h0, M},
        '{1'b1, OFS_PROT, 4'hF, UNL, 32'h0}, '{1'b0, OFS_PROT, 4'hF, 32'h0, 32'h0}};
    logic        clk     = 1'b0;
    logic        resetN  = 1'b0;
    logic        cyc     = 1'b0;
    logic        stb     = 1'b0;
    logic        we      = 1'b0;
    logic [3:0]  adr     = 4'h0;
    logic [3:0]  sel     = 4'h0;
    logic [31:0] datIn   = 32'h0;
    logic [31:0] datOut;
    logic        ack;
    logic        intOsc  = 1'b0;
    logic        extOsc  = 1'b0;
    logic        dbgHalt = 1'b0;
    logic        sysRst;
    logic [7:0]  oscCnt  = 8'h00;
    logic [31:0] q;
    int          nFail   = 0;
    int          nTests  = 0;
    int          n;

    watchdog_unit dut_u (
        .clk(clk), .reset_n(resetN), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datIn), .wb_dat_o(datOut), .wb_ack_o(ack),
        .lowSpeedInternalOsc(intOsc), .lowSpeedExternalOsc(extOsc),
        .debugHalt(dbgHalt), .sysResetReq(sysRst)
    );

    // 20 MHz clock
    always #25 clk = ~clk;

    // Slow oscillators at two different rates
    always @(posedge clk) begin
        oscCnt <= oscCnt + 8'h01;
        intOsc <= oscCnt[2];
        extOsc <= oscCnt[3];
    end

    // One classic Wishbone cycle, held until ack
    task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        sel   <= s;
        datIn <= d;
        do @(posedge clk); while (ack !== 1'b1);
        r = datOut;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic doReset;
        resetN <= 1'b0;
        repeat (2) @(posedge clk);
        resetN <= 1'b1;
    endtask

    task automatic finishTest;
        $display("Checks %0d, mismatches %0d", nTests, nFail);
        if (nFail == 0 && nTests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog on the whole run
    initial begin
        repeat (20000) @(posedge clk);
        nFail++;
        finishTest;
    end

    initial begin
        repeat (20) @(posedge clk);
        resetN <= 1'b1;
        bus(1'b0, OFS_MODE, 4'hF, 32'h0, q);
        `CHK(q, 32'hFFFF_FF00)
        bus(1'b0, OFS_STATUS, 4'hF, 32'h0, q);
        `CHK(q, 32'h0000_0FFF)
        foreach (ROWS[i]) begin
            bus(ROWS[i].we, ROWS[i].adr, ROWS[i].sel, ROWS[i].dat, q);
            if (!ROWS[i].we) `CHK(q, ROWS[i].want)
        end
        // No reload: underflow from internal source
        bus(1'b1, OFS_MODE, 4'hF, M | 32'h1, q);
        while (sysRst !== 1'b1) @(posedge clk);
        bus(1'b0, OFS_STATUS, 4'hF, 32'h0, q);
        `CHK(q[14:12], 3'b011)
        // Reload while count is above delta
        doReset;
        bus(1'b1, OFS_MODE, 4'hF, M | 32'h1, q);
        bus(1'b1, OFS_CTRL, 4'hF, 32'h5FA0_0001, q);
        repeat (3) @(posedge clk);
        `CHK(sysRst, 1'b1)
        bus(1'b0, OFS_STATUS, 4'hF, 32'h0, q);
        `CHK(q[14:12], 3'b101)
        // Debug freeze, then external source with divide by 2
        doReset;
        bus(1'b1, OFS_MODE, 4'hF, M, q); // Load reload value while disabled
        dbgHalt <= 1'b1;
        bus(1'b1, OFS_MODE, 4'hF, M | 32'h17, q);
        repeat (200) @(posedge clk);
        bus(1'b0, OFS_STATUS, 4'hF, 32'h0, q);
        `CHK(q[11:0], 12'h00A)
        dbgHalt <= 1'b0;
        n = 0;
        do begin bus(1'b0, OFS_STATUS, 4'hF, 32'h0, q); n++; end while (q[11:0] > 12'h005 && n < 200);
        `CHK(q[11:0] <= 12'h005, 1'b1)
        bus(1'b1, OFS_CTRL, 4'hF, 32'h5FA0_0001, q);
        repeat (250) @(posedge clk);
        `CHK(sysRst, 1'b0)
        finishTest;
    end
endmodule
